// ### hdl/flash_erase_program.v
// erase and page program command sequencer of a serial nor flash
`timescale 1ns/1ps
`include "flash_cmd_map.vh"

module flash_erase_program #(
  parameter ADDR_W                  = 24,      // array byte address width
  parameter NUM_BLK64               = 8,       // 64k blocks in the array
  parameter ERASE32K_CYCLE_TIME_US  = 150000,  // 32k erase cycle time, us
  parameter ERASE64K_CYCLE_TIME_US  = 300000,  // 64k erase cycle time, us
  parameter CHIP_ERASE_TIME_US      = 2000000, // chip erase cycle time, us
  parameter PAGE_PROGRAM_TIME_US    = 1000     // page program cycle time, us
) (
  input  wire              clk_sys,              // system clock, 100 mhz
  input  wire              nrst,                 // synchronous reset, active low
  input  wire              cs_n,                 // chip select pin, active low
  input  wire              sclk,                 // serial clock pin
  input  wire [3:0]        data_line,            // data_line0..3 pins, input side
  input  wire              write_enable_cmd,     // pulse: write enable command decoded
  input  wire              quad_enable_bit,      // quad enable status bit
  input  wire              qpi_mode,             // device is in qpi mode
  input  wire [4:0]        block_protect,        // block protect bits, bit 4 first
  output reg               write_in_progress,    // self-timed cycle running
  output reg               write_enable_latch,   // write enable latch
  output reg               cmd_reject,           // pulse: command dropped at select rise while idle
  output reg               arr_erase,            // pulse: erase the given region
  output reg  [1:0]        arr_erase_size,       // 32k, 64k or whole array
  output reg               arr_wr,               // pulse: program one byte
  output reg  [ADDR_W-1:0] arr_addr,             // region base or byte address
  output reg  [7:0]        arr_wdata             // byte to program
);

  // cycle counts derived from the cycle times
  localparam [31:0] ERASE32K_CYC = ERASE32K_CYCLE_TIME_US * `CLK_MHZ;
  localparam [31:0] ERASE64K_CYC = ERASE64K_CYCLE_TIME_US * `CLK_MHZ;
  localparam [31:0] CHIP_CYC     = CHIP_ERASE_TIME_US * `CLK_MHZ;
  localparam [31:0] PROG_CYC     = PAGE_PROGRAM_TIME_US * `CLK_MHZ;

  // frame phases
  localparam [2:0] PH_CMD  = 3'h0;
  localparam [2:0] PH_ADDR = 3'h1;
  localparam [2:0] PH_DATA = 3'h2;
  localparam [2:0] PH_DONE = 3'h3;
  localparam [2:0] PH_BAD  = 3'h4;

  // cycle states
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_PROG  = 2'h1;
  localparam [1:0] ST_WAIT  = 2'h2;

  // pin synchronisers, first stage read only by second
  reg              cs_s1_q, cs_s2_q, cs_s3_q;   // select sync plus edge stage
  reg              sck_s1_q, sck_s2_q, sck_s3_q; // clock sync plus edge stage
  reg  [3:0]       dq_s1_q, dq_s2_q;            // data lines sync

  // frame capture
  reg  [2:0]       ph_q;                        // frame phase
  reg  [3:0]       bit_q;                       // bits held of current byte
  reg  [7:0]       sh_q;                        // shift register
  reg  [7:0]       op_q;                        // latched opcode
  reg  [ADDR_W-1:0] addr_q;                     // latched address
  reg  [1:0]       acnt_q;                      // address bytes received
  reg              got_data_q;                  // at least one data byte
  reg  [7:0]       ptr_q;                       // in-page write pointer
  reg  [7:0]       page_q [0:255];              // page data buffer
  reg  [255:0]     mask_q;                      // which buffer bytes are loaded

  // cycle control
  reg  [1:0]       st_q;                        // cycle state
  reg  [31:0]      tmr_q;                       // self-timed cycle counter
  reg  [8:0]       idx_q;                       // program stream index
  reg              prot_q;                      // accepted command is guarded
  reg  [ADDR_W-1:0] base_q;                     // page base for streaming

  wire sck_rise = sck_s2_q & ~sck_s3_q;        // serial clock rising edge
  wire cs_fall  = ~cs_s2_q & cs_s3_q;          // frame start
  wire cs_rise  = cs_s2_q & ~cs_s3_q;          // frame end
  wire in_frame = ~cs_s2_q;                    // select held low

  // opcode classes
  wire is_e32 = (op_q == `OP_BLOCK_ERASE_32K);
  wire is_e64 = (op_q == `OP_BLOCK_ERASE_64K);
  wire is_ce  = (op_q == `OP_CHIP_ERASE_A) || (op_q == `OP_CHIP_ERASE_B);
  wire is_prog  = (op_q == `OP_PAGE_PROGRAM);
  wire is_qprog = (op_q == `OP_QUAD_PAGE_PROGRAM);

  // four lines per edge in qpi mode or quad data phase
  wire       quad_step = qpi_mode | ((ph_q == PH_DATA) & is_qprog);
  // single-line shifts read data_line0 only
  wire [7:0] sh_nxt    = quad_step ? {sh_q[3:0], dq_s2_q} : {sh_q[6:0], dq_s2_q[0]};
  wire [3:0] bit_nxt   = bit_q + (quad_step ? `STEP_QUAD : `STEP_SINGLE);
  wire       byte_done = (bit_nxt == `BYTE_BITS);

  // protection of the top blocks of the array
  function prot_hit;
    input [4:0] bp;                             // protect setting
    input [ADDR_W-1:0] a;                       // address to test
    integer n;                                  // protected 64k blocks
    integer blk;                                // block index of address
    begin
      n   = (bp == 5'h00) ? 0 : (1 << (bp - 5'h01));
      if (n > NUM_BLK64) begin
        n = NUM_BLK64;
      end
      blk = a >> `BLK64_LSB;
      prot_hit = (n != 0) && (blk >= NUM_BLK64 - n);
    end
  endfunction

  // a frame is complete only at an exact byte boundary
  wire erase_ok = (is_e32 | is_e64 | is_ce) & (ph_q == PH_DONE);
  wire prog_ok  = (is_prog | (is_qprog & quad_enable_bit)) & (ph_q == PH_DATA)
                  & got_data_q & (bit_q == 4'h0);
  wire accept   = cs_rise & (st_q == ST_IDLE) & ~write_in_progress
                  & write_enable_latch & (erase_ok | prog_ok);
  wire guarded  = is_ce ? (block_protect != 5'h00)
                        : prot_hit(block_protect, addr_q);

  // two flip-flop synchronisers on every pin
  always @(posedge clk_sys) begin
    if (!nrst) begin
      cs_s1_q  <= 1'b1;
      cs_s2_q  <= 1'b1;
      cs_s3_q  <= 1'b1;
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
      dq_s1_q  <= 4'h0;
      dq_s2_q  <= 4'h0;
    end else begin
      cs_s1_q  <= cs_n;
      cs_s2_q  <= cs_s1_q;
      cs_s3_q  <= cs_s2_q;
      sck_s1_q <= sclk;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      dq_s1_q  <= data_line;
      dq_s2_q  <= dq_s1_q;
    end
  end

  // frame decoder: opcode, address bytes, data bytes
  always @(posedge clk_sys) begin
    if (!nrst) begin
      ph_q       <= PH_CMD;
      bit_q      <= 4'h0;
      sh_q       <= 8'h00;
      op_q       <= 8'h00;
      addr_q     <= {ADDR_W{1'b0}};
      acnt_q     <= 2'h0;
      got_data_q <= 1'b0;
      ptr_q      <= 8'h00;
    end else if (cs_fall) begin
      // new frame, forget the last one
      ph_q       <= PH_CMD;
      bit_q      <= 4'h0;
      acnt_q     <= 2'h0;
      got_data_q <= 1'b0;
    end else if (in_frame && sck_rise) begin
      sh_q  <= sh_nxt;
      bit_q <= byte_done ? 4'h0 : bit_nxt;
      if (ph_q == PH_DONE) begin
        // any clock past a complete erase frame spoils it
        ph_q <= PH_BAD;
      end else if (byte_done) begin
        case (ph_q)
          PH_CMD: begin
            op_q <= sh_nxt;
            if ((sh_nxt == `OP_CHIP_ERASE_A) || (sh_nxt == `OP_CHIP_ERASE_B)) begin
              ph_q <= PH_DONE;
            end else if ((sh_nxt == `OP_BLOCK_ERASE_32K) ||
                         (sh_nxt == `OP_BLOCK_ERASE_64K) ||
                         (sh_nxt == `OP_PAGE_PROGRAM) ||
                         (sh_nxt == `OP_QUAD_PAGE_PROGRAM)) begin
              ph_q <= PH_ADDR;
            end else begin
              ph_q <= PH_BAD;                  // not ours, left to other blocks
            end
          end
          PH_ADDR: begin
            addr_q <= {addr_q[ADDR_W-9:0], sh_nxt};
            acnt_q <= acnt_q + 2'h1;
            if (acnt_q == `ADDR_BYTES_LAST) begin
              ptr_q <= sh_nxt;                 // low address byte starts the pointer
              ph_q  <= (is_prog | is_qprog) ? PH_DATA : PH_DONE;
            end
          end
          PH_DATA: begin
            ptr_q      <= ptr_q + 8'h01;       // wraps inside the page
            got_data_q <= 1'b1;
          end
          default: begin
            ph_q <= ph_q;
          end
        endcase
      end
    end
  end

  // page buffer: later bytes overwrite earlier ones at the same offset
  always @(posedge clk_sys) begin
    if (!nrst) begin
      mask_q <= {256{1'b0}};
    end else if (cs_fall && (st_q == ST_IDLE)) begin
      // buffer kept while a program cycle still drains it
      mask_q <= {256{1'b0}};
    end else if (in_frame && sck_rise && byte_done && (ph_q == PH_DATA) &&
                 (st_q == ST_IDLE)) begin
      page_q[ptr_q] <= sh_nxt;
      mask_q[ptr_q] <= 1'b1;
    end
  end

  // self-timed cycle: accept, stream, wait, release flags
  always @(posedge clk_sys) begin
    if (!nrst) begin
      st_q               <= ST_IDLE;
      tmr_q              <= 32'h0000_0000;
      idx_q              <= 9'h000;
      prot_q             <= 1'b0;
      base_q             <= {ADDR_W{1'b0}};
      write_in_progress  <= 1'b0;
      write_enable_latch <= 1'b0;
      cmd_reject         <= 1'b0;
      arr_erase          <= 1'b0;
      arr_erase_size     <= `ERASE_32K;
      arr_wr             <= 1'b0;
      arr_addr           <= {ADDR_W{1'b0}};
      arr_wdata          <= 8'h00;
    end else begin
      arr_erase  <= 1'b0;
      arr_wr     <= 1'b0;
      cmd_reject <= 1'b0;
      // latch set only outside a running cycle
      if (write_enable_cmd && !write_in_progress) begin
        write_enable_latch <= 1'b1;
      end
      case (st_q)
        ST_IDLE: begin
          if (accept) begin
            write_in_progress <= 1'b1;
            prot_q            <= guarded;
            idx_q             <= 9'h000;
            base_q            <= (addr_q >> `PAGE_LSB) << `PAGE_LSB;
            if (is_prog | is_qprog) begin
              tmr_q <= PROG_CYC;
              st_q  <= ST_PROG;
            end else begin
              st_q <= ST_WAIT;
              // erase region issued only when unguarded
              arr_erase <= ~guarded;
              if (is_ce) begin
                tmr_q          <= CHIP_CYC;
                arr_erase_size <= `ERASE_CHIP;
                arr_addr       <= {ADDR_W{1'b0}};
              end else if (is_e64) begin
                tmr_q          <= ERASE64K_CYC;
                arr_erase_size <= `ERASE_64K;
                arr_addr       <= (addr_q >> `BLK64_LSB) << `BLK64_LSB;
              end else begin
                tmr_q          <= ERASE32K_CYC;
                arr_erase_size <= `ERASE_32K;
                arr_addr       <= (addr_q >> `BLK32_LSB) << `BLK32_LSB;
              end
            end
          end else if (cs_rise && (ph_q != PH_CMD)) begin
            // frame of ours that does not qualify
            cmd_reject <= (erase_ok | prog_ok | is_e32 | is_e64 | is_ce | is_prog
                           | is_qprog) & ~(erase_ok | prog_ok)
                          | ((erase_ok | prog_ok) & ~(write_enable_latch
                             & ~write_in_progress));
          end
        end
        ST_PROG: begin
          // one buffered byte per cycle, offsets 0..255
          tmr_q <= (tmr_q != 32'h0000_0000) ? tmr_q - 32'h0000_0001 : tmr_q;
          if (idx_q[8]) begin
            st_q <= ST_WAIT;
          end else begin
            idx_q     <= idx_q + 9'h001;
            arr_wr    <= mask_q[idx_q[7:0]] & ~prot_q;
            arr_addr  <= base_q | {{(ADDR_W-8){1'b0}}, idx_q[7:0]};
            arr_wdata <= page_q[idx_q[7:0]];
          end
        end
        ST_WAIT: begin
          if (tmr_q <= 32'h0000_0001) begin
            // completion drops both flags together
            st_q               <= ST_IDLE;
            tmr_q              <= 32'h0000_0000;
            write_in_progress  <= 1'b0;
            write_enable_latch <= 1'b0;
          end else begin
            tmr_q <= tmr_q - 32'h0000_0001;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // flash_erase_program

// ### pkg/flash_cmd_map.vh
// opcodes, field positions, widths and clock figures of the erase and program sequencer
`ifndef FLASH_CMD_MAP_VH
`define FLASH_CMD_MAP_VH

// command opcodes taken by this block
`define OP_BLOCK_ERASE_32K   8'h52
`define OP_BLOCK_ERASE_64K   8'hD8
`define OP_CHIP_ERASE_A      8'h60
`define OP_CHIP_ERASE_B      8'hC7
`define OP_PAGE_PROGRAM      8'h02
`define OP_QUAD_PAGE_PROGRAM 8'h32

// serial framing
`define BYTE_BITS            4'h8
`define STEP_SINGLE          4'h1
`define STEP_QUAD            4'h4
`define ADDR_BYTES_LAST      2'h2

// address field positions
`define BLK32_LSB            15
`define BLK64_LSB            16
`define PAGE_LSB             8

// erase size codes on the array port
`define ERASE_32K            2'h0
`define ERASE_64K            2'h1
`define ERASE_CHIP           2'h2

// system clock rate in MHz
`define CLK_MHZ              100

`endif

// ### verification/flash_erase_program_assertions.sv
// port checker for the erase and program sequencer
`timescale 1ns/1ps
`include "flash_cmd_map.vh"
module flash_erase_program_assertions #(
  parameter ADDR_W                 = 24, // byte address width
  parameter ERASE32K_CYCLE_TIME_US = 5,  // 32k cycle, us
  parameter ERASE64K_CYCLE_TIME_US = 5,  // 64k cycle, us
  parameter CHIP_ERASE_TIME_US     = 5,  // chip cycle, us
  parameter PAGE_PROGRAM_TIME_US   = 5   // program cycle, us
) (
  input wire              clk_sys,            // system clock
  input wire              nrst,               // sync reset, low
  input wire              cs_n,               // chip select
  input wire              sclk,               // link clock
  input wire [3:0]        data_line,          // link data
  input wire              write_enable_cmd,   // latch set pulse
  input wire              quad_enable_bit,    // quad allowed
  input wire              qpi_mode,           // four-line mode
  input wire [4:0]        block_protect,      // protect setting
  input wire              write_in_progress,  // timed cycle
  input wire              write_enable_latch, // latch
  input wire              cmd_reject,         // dropped frame
  input wire              arr_erase,          // erase pulse
  input wire [1:0]        arr_erase_size,     // erase size code
  input wire              arr_wr,             // byte write pulse
  input wire [ADDR_W-1:0] arr_addr,           // array address
  input wire [7:0]        arr_wdata           // array data
);
  reg [31:0] busy_len_q; // edges seen with the cycle running
  // cycle length counter, cleared whenever idle
  always @(posedge clk_sys) begin
    if (!nrst || !write_in_progress) busy_len_q <= 32'h0000_0000;
    else busy_len_q <= busy_len_q + 32'h0000_0001;
  end
  // one cycle of slack either side: the exact launch edge is a design choice
  function automatic logic near(input [31:0] n, input integer us);
    near = (n + 32'h0000_0001 >= us * `CLK_MHZ) && (n <= us * `CLK_MHZ + 1);
  endfunction
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  erase_at_start_a: assert property (arr_erase |-> $rose(write_in_progress) && !arr_wr)
    else $error("erase pulse not at cycle start");
  erase_single_a: assert property (arr_erase |=> !arr_erase [*8])
    else $error("erase pulse repeated");
  base_32k_a: assert property (arr_erase && arr_erase_size == `ERASE_32K
    |-> arr_addr[14:0] == 15'h0000) else $error("32k erase base not aligned");
  base_64k_a: assert property (arr_erase && arr_erase_size == `ERASE_64K
    |-> arr_addr[15:0] == 16'h0000) else $error("64k erase base not aligned");
  chip_open_a: assert property (arr_erase && arr_erase_size == `ERASE_CHIP
    |-> block_protect == 5'h00) else $error("chip erase while guarded");
  top_guard_a: assert property ((arr_erase || arr_wr) && block_protect == 5'h01
    |-> arr_addr[ADDR_W-1:16] != 7) else $error("guarded block touched");
  wr_ascend_a: assert property (arr_wr && $past(arr_wr) |-> arr_addr[ADDR_W-1:8] ==
    $past(arr_addr[ADDR_W-1:8]) && arr_addr[7:0] == $past(arr_addr[7:0]) + 8'h01)
    else $error("page write not ascending in page");
  wr_window_a: assert property (arr_wr |-> write_in_progress &&
    busy_len_q <= 32'h0000_0101) else $error("byte write outside stream window");
  reject_idle_a: assert property (cmd_reject && !write_in_progress
    |-> !arr_erase ##1 !write_in_progress) else $error("rejected frame started a cycle");
  wip_end_a: assert property ($fell(write_in_progress) |-> !write_enable_latch &&
    (near(busy_len_q, ERASE32K_CYCLE_TIME_US) || near(busy_len_q, ERASE64K_CYCLE_TIME_US) ||
     near(busy_len_q, CHIP_ERASE_TIME_US) || near(busy_len_q, PAGE_PROGRAM_TIME_US)))
    else $error("cycle end wrong length or latch kept");
  cover property (arr_erase);
  cover property (arr_wr && arr_addr[7:0] == 8'hff);
  cover property (cmd_reject);
endmodule // flash_erase_program_assertions

bind flash_erase_program flash_erase_program_assertions #(.ADDR_W(ADDR_W),
  .ERASE32K_CYCLE_TIME_US(ERASE32K_CYCLE_TIME_US), .ERASE64K_CYCLE_TIME_US(ERASE64K_CYCLE_TIME_US),
  .CHIP_ERASE_TIME_US(CHIP_ERASE_TIME_US), .PAGE_PROGRAM_TIME_US(PAGE_PROGRAM_TIME_US))
  chk_inst (.clk_sys(clk_sys), .nrst(nrst), .cs_n(cs_n), .sclk(sclk), .data_line(data_line),
  .write_enable_cmd(write_enable_cmd), .quad_enable_bit(quad_enable_bit), .qpi_mode(qpi_mode),
  .block_protect(block_protect), .write_in_progress(write_in_progress),
  .write_enable_latch(write_enable_latch), .cmd_reject(cmd_reject), .arr_erase(arr_erase),
  .arr_erase_size(arr_erase_size), .arr_wr(arr_wr), .arr_addr(arr_addr), .arr_wdata(arr_wdata));

// ### verification/host_spi_model.sv
// host side link master driving select, clock and data lines
`timescale 1ns/1ps
module host_spi_model (
  input  wire       clk_sys,  // paces the link
  output reg        cs_n,     // chip select, low
  output reg        sclk,     // link clock, still between frames
  output reg  [3:0] data_line // data toward the device
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    data_line = 4'h0;
  end
  // one 80 ns link clock: data set while low, taken on the rise
  task automatic tick(input [3:0] d);
    begin
      @(negedge clk_sys);
      sclk = 1'b0;
      data_line = d;
      repeat (4) @(negedge clk_sys);
      sclk = 1'b1;
      repeat (3) @(negedge clk_sys);
    end
  endtask
  // select falls to open a frame
  task automatic open;
    @(negedge clk_sys) cs_n = 1'b0;
  endtask
  // top nb bits msb first; quad sends two nibbles, high first
  task automatic put(input [7:0] b, input q, input integer nb);
    integer i;
    begin
      if (q) begin
        tick(b[7:4]);
        tick(b[3:0]);
      end else begin
        // upper lines carry junk so a device must ignore them
        for (i = 7; i >= 8 - nb; i--) tick({~b[i], b[i], ~b[i], b[i]});
      end
    end
  endtask
  // clock back low, then select rises; released lines flip
  task automatic close;
    begin
      @(negedge clk_sys);
      sclk = 1'b0;
      repeat (4) @(negedge clk_sys);
      cs_n = 1'b1;
      data_line = ~data_line;
    end
  endtask
endmodule // host_spi_model

// ### verification/serial_flash_erase_program_cmds_tb.sv
// self-checking bench for the erase and program sequencer
`timescale 1ns/1ps
`include "flash_cmd_map.vh"
module serial_flash_erase_program_cmds_tb;
  reg         clk_sys = 1'b0;          // 100 mhz
  reg         nrst = 1'b0;             // sync reset
  reg         write_enable_cmd = 1'b0; // latch set pulse
  reg         quad_enable_bit = 1'b0;  // quad allowed
  reg         qpi_mode = 1'b0;         // four-line mode for the whole frame
  reg  [4:0]  block_protect = 5'h00;   // protect setting
  wire        cs_n, sclk, write_in_progress, write_enable_latch, cmd_reject, arr_erase, arr_wr;
  wire [3:0]  data_line;
  wire [1:0]  arr_erase_size;
  wire [23:0] arr_addr;
  wire [7:0]  arr_wdata;
  integer     num_errors = 0, checked = 0, n_er, n_wr, n_rej; // tallies
  reg  [1:0]  er_size;                 // last erase size
  reg  [23:0] er_addr;                 // last erase base
  reg  [15:0] wpage;                   // last written page
  reg  [7:0]  wdat [0:255];            // bytes seen per offset
  always #5 clk_sys = ~clk_sys;
  flash_erase_program #(.ERASE32K_CYCLE_TIME_US(5), .ERASE64K_CYCLE_TIME_US(5),
    .CHIP_ERASE_TIME_US(5), .PAGE_PROGRAM_TIME_US(5)) flash_erase_program_inst (
    .clk_sys(clk_sys), .nrst(nrst), .cs_n(cs_n), .sclk(sclk), .data_line(data_line),
    .write_enable_cmd(write_enable_cmd), .quad_enable_bit(quad_enable_bit), .qpi_mode(qpi_mode),
    .block_protect(block_protect), .write_in_progress(write_in_progress),
    .write_enable_latch(write_enable_latch), .cmd_reject(cmd_reject), .arr_erase(arr_erase),
    .arr_erase_size(arr_erase_size), .arr_wr(arr_wr), .arr_addr(arr_addr), .arr_wdata(arr_wdata));
  host_spi_model host_spi_model_inst (.clk_sys(clk_sys), .cs_n(cs_n), .sclk(sclk),
    .data_line(data_line));
  // array port monitor
  always @(posedge clk_sys) begin
    if (arr_erase === 1'b1) begin
      n_er++;
      er_size = arr_erase_size;
      er_addr = arr_addr;
    end
    if (arr_wr === 1'b1) begin
      n_wr++;
      wdat[arr_addr[7:0]] = arr_wdata;
      wpage = arr_addr[23:8];
    end
    if (cmd_reject === 1'b1) n_rej++;
  end
  task automatic chk(input string what, input [31:0] seen, input [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // latch, one frame, then wait out any timed cycle
  task automatic issue(input [7:0] op, input [23:0] a, input integer na, input integer nd,
                       input q, input integer extra, input ok);
    integer i;
    begin
      n_er = 0;
      n_wr = 0;
      n_rej = 0;
      @(negedge clk_sys) write_enable_cmd = 1'b1;
      @(negedge clk_sys) write_enable_cmd = 1'b0;
      host_spi_model_inst.open();
      host_spi_model_inst.put(op, qpi_mode, 8);
      for (i = 0; i < na; i++) host_spi_model_inst.put(a[23-8*i -: 8], qpi_mode, 8);
      for (i = 0; i < nd; i++) host_spi_model_inst.put(i < 256 ? 8'ha0 + i[7:0] : 8'h5a, q, 8);
      if (extra > 0) host_spi_model_inst.put(8'hff, 1'b0, extra);
      host_spi_model_inst.close();
      repeat (8) @(negedge clk_sys);
      chk("busy", write_in_progress, ok);
      for (i = 0; i < 700 && write_in_progress !== 1'b0; i++) @(negedge clk_sys);
      chk("idle", write_in_progress, 0);
      chk("latch", write_enable_latch, !ok);
    end
  endtask
  task automatic t_erase;
    begin
      block_protect = 5'h00;
      issue(`OP_BLOCK_ERASE_32K, 24'h00_9abc, 3, 0, 0, 0, 1);
      chk("e32 count", n_er, 1);
      chk("e32 base", er_addr, 24'h00_8000);
      chk("e32 size", er_size, `ERASE_32K);
      issue(`OP_BLOCK_ERASE_64K, 24'h03_4567, 3, 0, 0, 0, 1);
      chk("e64 base", er_addr, 24'h03_0000);
      chk("e64 size", er_size, `ERASE_64K);
      block_protect = 5'h01;
      issue(`OP_BLOCK_ERASE_64K, 24'h05_0000, 3, 0, 0, 0, 1);
      chk("e64 open block", er_addr, 24'h05_0000);
      issue(`OP_BLOCK_ERASE_32K, 24'h07_9000, 3, 0, 0, 0, 1);
      chk("e32 guarded", n_er, 0);
      issue(`OP_BLOCK_ERASE_64K, 24'h07_1234, 3, 0, 0, 0, 1);
      chk("e64 guarded", n_er, 0);
      $display("test erase done");
    end
  endtask
  task automatic t_chip;
    begin
      block_protect = 5'h00;
      issue(`OP_CHIP_ERASE_A, 24'h00_0000, 0, 0, 0, 0, 1);
      chk("chip a size", er_size, `ERASE_CHIP);
      issue(`OP_CHIP_ERASE_B, 24'h00_0000, 0, 0, 0, 0, 1);
      chk("chip b count", n_er, 1);
      block_protect = 5'h01;
      issue(`OP_CHIP_ERASE_B, 24'h00_0000, 0, 0, 0, 0, 1);
      chk("chip guarded", n_er, 0);
      $display("test chip done");
    end
  endtask
  task automatic t_program;
    begin
      block_protect = 5'h00;
      // every page below was erased by the chip erase; all but the guarded one at 24'h07_0010 are programmed once
      issue(`OP_PAGE_PROGRAM, 24'h01_23f0, 3, 20, 0, 0, 1);
      chk("prog count", n_wr, 20);
      chk("prog first", wdat[8'hf0], 8'ha0);
      chk("prog wrapped", wdat[8'h03], 8'hb3);
      chk("prog page", wpage, 16'h0123);
      quad_enable_bit = 1'b1;
      issue(`OP_QUAD_PAGE_PROGRAM, 24'h02_0000, 3, 260, 1, 0, 1);
      chk("quad count", n_wr, 256);
      chk("quad late", wdat[8'h02], 8'h5a);
      chk("quad mid", wdat[8'hc8], 8'h68);
      qpi_mode = 1'b1;
      issue(`OP_PAGE_PROGRAM, 24'h03_0010, 3, 4, 1, 0, 1);
      chk("four-line count", n_wr, 4);
      chk("four-line last", wdat[8'h13], 8'ha3);
      chk("four-line page", wpage, 16'h0300);
      qpi_mode = 1'b0;
      block_protect = 5'h01;
      issue(`OP_PAGE_PROGRAM, 24'h07_0010, 3, 4, 0, 0, 1);
      chk("prog guarded", n_wr, 0);
      $display("test program done");
    end
  endtask
  task automatic t_reject;
    begin
      block_protect = 5'h00;
      issue(`OP_BLOCK_ERASE_32K, 24'h00_1200, 2, 0, 0, 0, 0);
      chk("short erase", n_rej, 1);
      issue(`OP_BLOCK_ERASE_64K, 24'h01_0000, 3, 0, 0, 4, 0);
      chk("long erase", n_er, 0);
      issue(`OP_PAGE_PROGRAM, 24'h00_0100, 3, 2, 0, 3, 0);
      chk("ragged prog", n_wr, 0);
      quad_enable_bit = 1'b0;
      issue(`OP_QUAD_PAGE_PROGRAM, 24'h00_0100, 3, 2, 1, 0, 0);
      chk("quad no enable", n_rej, 1);
      $display("test reject done");
    end
  endtask
  task automatic conclude;
    begin
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #1_000_000;
    num_errors++;
    conclude;
  end
  initial begin
    repeat (8) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_erase;
    t_chip;
    t_program;
    t_reject;
    conclude;
  end
endmodule // serial_flash_erase_program_cmds_tb
